// ===== core/ccu_capture_compare_unit.sv
// Capture/compare unit: edge prescaler, 16-bit capture and 16-bit match against the timer pair.
// Contract
// - Four capture prescaler choices are selected by the 4-bit mode field.
// - Prescaler counter is held at zero when off or not in capture mode.
// - Every reset clears the prescaler counter.
// - Direct change between capture prescalers may raise a spurious flag.
// - Direct change between capture prescalers leaves the counter unchanged.
// - In compare mode the match register is compared with the timer every clock.
// - On match the pin goes high, low or stays, per mode field.
// - The interrupt flag is set in the same cycle as the match pin action.
// - In capture mode a selected pin event copies the timer into the value register.
// - Events: every falling, every rising, every fourth or sixteenth rising edge.
// - Each capture sets the flag; only software or reset clears it; captures overwrite.
`timescale 1ns/10ps
module ccu_capture_compare_unit #(
   parameter logic [3:0] CODE_OFF = ccu_pkg::MODE_OFF,
   parameter logic [3:0] CODE_CAP_FALL = ccu_pkg::MODE_CAP_FALL,
   parameter logic [3:0] CODE_CAP_RISE = ccu_pkg::MODE_CAP_RISE,
   parameter logic [3:0] CODE_CAP_RISE4 = ccu_pkg::MODE_CAP_RISE4,
   parameter logic [3:0] CODE_CAP_RISE16 = ccu_pkg::MODE_CAP_RISE16,
   parameter logic [3:0] CODE_CMP_HIGH = ccu_pkg::MODE_CMP_HIGH,
   parameter logic [3:0] CODE_CMP_LOW = ccu_pkg::MODE_CMP_LOW,
   parameter logic [3:0] CODE_CMP_KEEP = ccu_pkg::MODE_CMP_KEEP
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [ccu_pkg::MODE_W-1:0] ccpModeField,
   input wire logic [ccu_pkg::TIMER_W-1:0] timerPair16,
   input wire logic matchWrEn,
   input wire logic [ccu_pkg::TIMER_W-1:0] matchWrData,
   input wire logic irqFlagClr,
   input wire logic ccpPinIn,
   output logic ccpPinOut,
   output logic ccpPinOe,
   output logic [ccu_pkg::TIMER_W-1:0] ccpValueReg,
   output logic ccpIrqFlag
);
   import ccu_pkg::*;

   // ======================================================
   // Elaboration check on the decode table: two equal codes would make one mode unreachable.
   localparam int N_CODES = 8;

   // True when any two entries of the packed code list are equal.
   function automatic logic codesClash(input logic [N_CODES*MODE_W-1:0] codes);
      logic clash;
      clash = 1'b0;
      for (int i = 0; i < N_CODES; i++) begin
         for (int j = i + 1; j < N_CODES; j++) begin
            if (codes[i*MODE_W +: MODE_W] == codes[j*MODE_W +: MODE_W]) begin
               clash = 1'b1;
            end
         end
      end
      return clash;
   endfunction

   if (codesClash({CODE_OFF, CODE_CAP_FALL, CODE_CAP_RISE, CODE_CAP_RISE4, CODE_CAP_RISE16,
                   CODE_CMP_HIGH, CODE_CMP_LOW, CODE_CMP_KEEP})) begin : g_codeClash
      $error("ccu: mode codes must be distinct");
   end

   // ======================================================
   // Mode decode. Codes not in the table behave as off.
   function automatic ccu_op_t decodeMode(input logic [MODE_W-1:0] m);
      ccu_op_t op;
      op = OP_OFF;
      if (m == CODE_CAP_FALL) op = OP_CAP_FALL;
      else if (m == CODE_CAP_RISE) op = OP_CAP_RISE;
      else if (m == CODE_CAP_RISE4) op = OP_CAP_RISE4;
      else if (m == CODE_CAP_RISE16) op = OP_CAP_RISE16;
      else if (m == CODE_CMP_HIGH) op = OP_CMP_HIGH;
      else if (m == CODE_CMP_LOW) op = OP_CMP_LOW;
      else if (m == CODE_CMP_KEEP) op = OP_CMP_KEEP;
      return op;
   endfunction

   ccu_op_t opNow;
   logic isCapture;
   logic isCompare;
   logic riseEvt;
   logic fallEvt;
   logic capEvt;
   logic matchHit;
   logic [PRESC_W-1:0] presc_q, presc_d;
   logic [TIMER_W-1:0] value_q, value_d;
   logic pin_q, pin_d;
   logic oe_q, oe_d;
   logic flag_q, flag_d;

   assign opNow = decodeMode(ccpModeField);
   assign isCapture = (opNow == OP_CAP_FALL) || (opNow == OP_CAP_RISE) ||
                      (opNow == OP_CAP_RISE4) || (opNow == OP_CAP_RISE16);
   assign isCompare = (opNow == OP_CMP_HIGH) || (opNow == OP_CMP_LOW) || (opNow == OP_CMP_KEEP);

   // ======================================================
   // Pin synchroniser and edge detection.
   ccu_edge_sync u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .pinIn(ccpPinIn),
      .riseEvt(riseEvt),
      .fallEvt(fallEvt)
   );

   // ======================================================
   // Capture event selection and prescaler. The counter is not cleared on a
   // direct prescaler change, so the first capture may come early; software
   // avoids that by writing off first.
   always_comb begin
      capEvt = 1'b0;
      presc_d = presc_q;
      case (opNow)
         OP_CAP_FALL: begin
            capEvt = fallEvt;
         end
         OP_CAP_RISE: begin
            capEvt = riseEvt;
         end
         OP_CAP_RISE4: begin
            if (riseEvt) begin
               capEvt = (presc_q[1:0] == PRESC_LAST4[1:0]);
               presc_d = presc_q + 4'h1;
            end
         end
         OP_CAP_RISE16: begin
            if (riseEvt) begin
               capEvt = (presc_q == PRESC_LAST16);
               presc_d = presc_q + 4'h1;
            end
         end
         default: begin
            presc_d = PRESC_ZERO;
         end
      endcase
   end

   // ======================================================
   // Compare match, continuously evaluated every clock.
   assign matchHit = isCompare && (timerPair16 == value_q);

   // Value register, pin driver and interrupt flag next values.
   always_comb begin
      value_d = value_q;
      pin_d = pin_q;
      oe_d = isCompare;
      flag_d = flag_q;
      if (irqFlagClr) begin
         flag_d = 1'b0;
      end
      if (matchWrEn) begin
         value_d = matchWrData;
      end
      if (capEvt) begin
         value_d = timerPair16;
         flag_d = 1'b1;
      end
      if (matchHit) begin
         flag_d = 1'b1;
         case (opNow)
            OP_CMP_HIGH: pin_d = 1'b1;
            OP_CMP_LOW: pin_d = 1'b0;
            default: pin_d = pin_q;
         endcase
      end
   end

   // Registers; reset clears counter, value, pin, enable and flag; the mode field input is not reset.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         presc_q <= PRESC_ZERO;
         value_q <= VALUE_RESET;
         pin_q <= 1'b0;
         oe_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         presc_q <= presc_d;
         value_q <= value_d;
         pin_q <= pin_d;
         oe_q <= oe_d;
         flag_q <= flag_d;
      end
   end

   assign ccpPinOut = pin_q;
   assign ccpPinOe = oe_q;
   assign ccpValueReg = value_q;
   assign ccpIrqFlag = flag_q;

   // ======================================================
   // Checks.
   presc_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
      !isCapture |=> presc_q == PRESC_ZERO) else $error("prescaler not cleared outside capture");
   presc_reset_a: assert property (@(posedge clk_sys) reset |=> presc_q == PRESC_ZERO)
      else $error("prescaler not cleared by reset");
   presc_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
      isCapture && !riseEvt |=> presc_q == $past(presc_q)) else $error("prescaler moved without edge");
   cap_copy_a: assert property (@(posedge clk_sys) disable iff (reset)
      capEvt |=> ccpValueReg == $past(timerPair16)) else $error("capture value wrong");
   cap_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
      capEvt |=> ccpIrqFlag) else $error("capture did not set flag");
   div16_a: assert property (@(posedge clk_sys) disable iff (reset)
      opNow == OP_CAP_RISE16 && riseEvt && presc_q != PRESC_LAST16 |-> !capEvt) else $error("early capture");
   fall_only_a: assert property (@(posedge clk_sys) disable iff (reset)
      opNow == OP_CAP_FALL |-> capEvt == fallEvt) else $error("falling capture wrong");
   match_high_a: assert property (@(posedge clk_sys) disable iff (reset)
      matchHit && opNow == OP_CMP_HIGH |=> ccpPinOut && ccpPinOe) else $error("pin not driven high");
   match_low_a: assert property (@(posedge clk_sys) disable iff (reset)
      matchHit && opNow == OP_CMP_LOW |=> !ccpPinOut) else $error("pin not driven low");
   match_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
      matchHit && opNow == OP_CMP_KEEP |=> ccpPinOut == $past(ccpPinOut)) else $error("pin changed");
   match_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
      matchHit |=> ccpIrqFlag) else $error("match did not set flag");
   compare_live_a: assert property (@(posedge clk_sys) disable iff (reset)
      isCompare && timerPair16 == ccpValueReg |-> matchHit) else $error("match missed");
endmodule

// ===== inc/ccu_pkg.sv
// Package with mode codes, widths and reset values of the capture/compare unit.
package ccu_pkg;
   // ======================================================
   // Widths.
   localparam int MODE_W = 4;
   localparam int TIMER_W = 16;
   localparam int PRESC_W = 4;

   // ======================================================
   // Default mode codes, overridable in the top module.
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_HIGH = 4'h8;
   localparam logic [3:0] MODE_CMP_LOW = 4'h9;
   localparam logic [3:0] MODE_CMP_KEEP = 4'ha;

   // ======================================================
   // Prescaler terminal counts and reset values.
   localparam logic [3:0] PRESC_LAST4 = 4'h3;
   localparam logic [3:0] PRESC_LAST16 = 4'hf;
   localparam logic [3:0] PRESC_ZERO = 4'h0;
   localparam logic [15:0] VALUE_RESET = 16'h0000;

   // Decoded operating class of the mode field.
   typedef enum logic [3:0] {
      OP_OFF, OP_CAP_FALL, OP_CAP_RISE, OP_CAP_RISE4, OP_CAP_RISE16,
      OP_CMP_HIGH, OP_CMP_LOW, OP_CMP_KEEP
   } ccu_op_t;
endpackage

// ===== core/ccu_edge_sync.sv
// Two-stage synchroniser and edge detector for the capture/compare pin.
`timescale 1ns/10ps
module ccu_edge_sync (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic pinIn,
   output logic riseEvt,
   output logic fallEvt
);
   logic meta_q, meta_d;
   logic sync_q, sync_d;
   logic prev_q, prev_d;

   // Next values; the first stage feeds only the second stage.
   always_comb begin
      meta_d = pinIn;
      sync_d = meta_q;
      prev_d = sync_q;
   end

   // Registers of the synchroniser chain.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   // Edges are seen one to two cycles after the pin moves.
   assign riseEvt = sync_q & ~prev_q;
   assign fallEvt = ~sync_q & prev_q;
endmodule

// ===== tb/ccu_far_model.sv
// Far-side model: a holdable 16-bit timer pair and the outside driver of the capture/compare pin.
`timescale 1ns/10ps
module ccu_far_model (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic holdTimer,
   input wire logic extLevel,
   input wire logic ccpPinOut,
   input wire logic ccpPinOe,
   output logic [15:0] timerPair16,
   output logic ccpPinIn
);
   logic [15:0] timer_q;
   // The timer can stand still, so that a capture has one exact expected value.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         timer_q <= 16'h0000;
      end else if (!holdTimer) begin
         timer_q <= timer_q + 16'h0001;
      end
   end
   assign timerPair16 = timer_q;
   // The unit owns the pin while it drives it; otherwise the outside level is seen.
   assign ccpPinIn = ccpPinOe ? ccpPinOut : extLevel;
endmodule

// ===== tb/testbench.sv
// Self-checking testbench of the capture/compare unit.
`timescale 1ns/10ps
module testbench;
   import ccu_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [3:0] mode = 4'h0;
   logic matchWrEn = 1'b0;
   logic [15:0] matchWrData = 16'h0000;
   logic irqFlagClr = 1'b0;
   logic holdTimer = 1'b1;
   logic extLevel = 1'b0;
   logic [15:0] timerPair16;
   logic [15:0] ccpValueReg;
   logic [15:0] expVal;
   logic ccpPinIn;
   logic ccpPinOut;
   logic ccpPinOe;
   logic ccpIrqFlag;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   ccu_capture_compare_unit i_ccu_capture_compare_unit (.clk_sys(clk_sys), .reset(reset), .ccpModeField(mode),
      .timerPair16(timerPair16), .matchWrEn(matchWrEn), .matchWrData(matchWrData), .irqFlagClr(irqFlagClr),
      .ccpPinIn(ccpPinIn), .ccpPinOut(ccpPinOut), .ccpPinOe(ccpPinOe), .ccpValueReg(ccpValueReg),
      .ccpIrqFlag(ccpIrqFlag));
   ccu_far_model i_ccu_far_model (.clk_sys(clk_sys), .reset(reset), .holdTimer(holdTimer), .extLevel(extLevel),
      .ccpPinOut(ccpPinOut), .ccpPinOe(ccpPinOe), .timerPair16(timerPair16), .ccpPinIn(ccpPinIn));
   // ======================================================
   // Clock, hang guard and shared helpers.
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   // The whole run needs about 900 cycles; the ceiling leaves ample margin.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Outputs are sampled 1 ns after the edge so that the edge's own updates have landed.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic setMode(input logic [3:0] m);
      @(posedge clk_sys) mode <= m;
      tick(2);
   endtask
   task automatic clearFlag();
      @(posedge clk_sys) irqFlagClr <= 1'b1;
      @(posedge clk_sys) irqFlagClr <= 1'b0;
      tick(1);
   endtask
   task automatic advance(input int n);
      @(posedge clk_sys) holdTimer <= 1'b0;
      tick(n);
      @(posedge clk_sys) holdTimer <= 1'b1;
      tick(1);
   endtask
   // Each pulse is long enough for the two-flop synchroniser to see both edges.
   task automatic pinEdges(input int n);
      repeat (n) begin
         @(posedge clk_sys) extLevel <= 1'b1;
         tick(4);
         @(posedge clk_sys) extLevel <= 1'b0;
         tick(6);
      end
   endtask
   // ======================================================
   // Scenarios.
   task automatic t_capture(input logic [3:0] m);
      setMode(MODE_OFF);
      setMode(m);
      advance(5);
      expVal = timerPair16;
      clearFlag();
      pinEdges(1);
      check(ccpValueReg, expVal);
      check({15'h0000, ccpIrqFlag}, 16'h0001);
      clearFlag();
      check({15'h0000, ccpIrqFlag}, 16'h0000);
      advance(3);
      expVal = timerPair16;
      pinEdges(1);
      check(ccpValueReg, expVal);
   endtask
   task automatic t_presc(input logic [3:0] m, input int n);
      setMode(MODE_OFF);
      setMode(m);
      clearFlag();
      pinEdges(n - 1);
      check({15'h0000, ccpIrqFlag}, 16'h0000);
      pinEdges(1);
      check({15'h0000, ccpIrqFlag}, 16'h0001);
   endtask
   // Six edges leave the count part way through a group of four; turning off must clear it.
   task automatic t_offClear();
      t_presc(MODE_CAP_RISE4, 4);
      pinEdges(2);
      check({15'h0000, ccpIrqFlag}, 16'h0001);
      setMode(MODE_OFF);
      setMode(MODE_CAP_RISE4);
      clearFlag();
      pinEdges(3);
      check({15'h0000, ccpIrqFlag}, 16'h0000);
      pinEdges(1);
      check({15'h0000, ccpIrqFlag}, 16'h0001);
   endtask
   // A direct switch keeps a count of 2, so only 14 more edges reach the sixteenth.
   task automatic t_direct();
      setMode(MODE_OFF);
      setMode(MODE_CAP_RISE4);
      clearFlag();
      pinEdges(2);
      check({15'h0000, ccpIrqFlag}, 16'h0000);
      setMode(MODE_CAP_RISE16);
      clearFlag();
      pinEdges(13);
      check({15'h0000, ccpIrqFlag}, 16'h0000);
      pinEdges(1);
      check({15'h0000, ccpIrqFlag}, 16'h0001);
      check(ccpValueReg, timerPair16);
   endtask
   // A reset in mid-count must leave the prescaler at zero, so four fresh edges are needed again.
   task automatic t_midReset();
      setMode(MODE_OFF);
      setMode(MODE_CAP_RISE4);
      clearFlag();
      pinEdges(2);
      @(posedge clk_sys) reset <= 1'b1;
      tick(3);
      @(posedge clk_sys) reset <= 1'b0;
      tick(2);
      check(ccpValueReg, 16'h0000);
      check({14'h0000, ccpIrqFlag, ccpPinOe}, 16'h0000);
      pinEdges(3);
      check({15'h0000, ccpIrqFlag}, 16'h0000);
      pinEdges(1);
      check({15'h0000, ccpIrqFlag}, 16'h0001);
   endtask
   task automatic t_compare(input logic [3:0] m, input logic pinExp);
      advance(2);
      setMode(m);
      @(posedge clk_sys) matchWrEn <= 1'b1;
      matchWrData <= timerPair16 + 16'h0003;
      @(posedge clk_sys) matchWrEn <= 1'b0;
      tick(1);
      clearFlag();
      tick(3);
      check({15'h0000, ccpIrqFlag}, 16'h0000);
      check({15'h0000, ccpPinOe}, 16'h0001);
      advance(6);
      check({15'h0000, ccpIrqFlag}, 16'h0001);
      check({15'h0000, ccpPinOut}, {15'h0000, pinExp});
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      tick(1);
      check(ccpValueReg, 16'h0000);
      check({14'h0000, ccpIrqFlag, ccpPinOe}, 16'h0000);
      t_capture(MODE_CAP_RISE);
      t_capture(MODE_CAP_FALL);
      t_presc(MODE_CAP_RISE4, 4);
      t_presc(MODE_CAP_RISE16, 16);
      t_offClear();
      t_direct();
      t_midReset();
      t_compare(MODE_CMP_HIGH, 1'b1);
      t_compare(MODE_CMP_LOW, 1'b0);
      t_compare(MODE_CMP_KEEP, 1'b0);
      tally_and_finish();
   end
endmodule
